// ===== hdl/sar_seq_defs.vh
// offsets, field positions, reset values and timing counts for the sequencer
`ifndef SAR_SEQ_DEFS_VH
`define SAR_SEQ_DEFS_VH
// ===========================================================
// register word offsets (each block spans 16 bytes)
`define REG_BLOCK_BYTES 16
`define OFF_CTRL_TWO 4'h2
`define OFF_CTRL_THREE 4'h3
`define OFF_CTRL_FOUR 4'h4
`define OFF_CTRL_FIVE 4'h5
`define OFF_STATUS 4'h6
`define OFF_TEST 4'h7
`define OFF_RESULT_SEL 4'h8
`define OFF_RESULT_DATA 4'ha
// ===========================================================
// field positions
`define CT2_PWR_UP 7
`define CT2_STOP_IN_WAIT 6
`define CT2_JUSTIFY_RIGHT 5
`define CT3_FREEZE_HI 1
`define CT3_FREEZE_LO 0
`define CT3_LEN_ONE 2
`define CT4_RES10 7
`define CT4_SAMPLE_HI 6
`define CT4_SAMPLE_LO 5
`define CT4_PRESCALE_HI 4
`define CT4_PRESCALE_LO 0
`define CT5_LEN_EIGHT 6
`define CT5_SCAN 5
`define CT5_MULT 4
`define CT5_CHAN_HI 2
`define CT5_CHAN_LO 0
`define TEST_RESET_BIT 0
// ===========================================================
// reset values
`define CT2_RESET 8'h00
`define CT3_RESET 8'h00
`define CT4_RESET 8'h01
`define CT5_RESET 8'h00
// ===========================================================
// phase lengths in module clocks
`define SAMPLE_CAP_CLKS 2
`define SAMPLE_AMP_CLKS 4
`define CONV_CLKS_8BIT 10
`define CONV_CLKS_10BIT 12
// freeze selections
`define FRZ_IGNORE 2'h0
`define FRZ_FINISH 2'h2
`define FRZ_NOW 2'h3
`endif

// ===== hdl/sar_prescaler.v
// prescaler and fixed divide by two giving a module clock enable
`timescale 1ns/1ps
module sar_prescaler #(
  parameter WIDTH = 5
) (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire run_in,
  input wire [WIDTH-1:0] ratio_in,
  output wire tick_out
);
  reg [WIDTH-1:0] count_reg;
  reg half_reg;
  wire wrap;
  // ratio field n divides by n+1, giving 1..32
  assign wrap = (count_reg >= ratio_in);
  // gated by the enable so a frozen divider cannot hold a tick high
  assign tick_out = run_in & wrap & half_reg & ce_in;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= {WIDTH{1'b0}};
      half_reg <= 1'b0;
    end else if (ce_in) begin
      if (!run_in) begin
        // held at zero while gated so restarts are clean
        count_reg <= {WIDTH{1'b0}};
        half_reg <= 1'b0;
      end else if (wrap) begin
        count_reg <= {WIDTH{1'b0}};
        half_reg <= ~half_reg;
      end else begin
        count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ===== hdl/sar_search.v
// successive approximation engine driven by comparator decisions
`timescale 1ns/1ps
`include "sar_seq_defs.vh"
module sar_search #(
  parameter BITS = 10
) (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire tick_in,
  input wire start_in,
  input wire abort_in,
  input wire res10_in,
  input wire comp_in,
  output wire [BITS-1:0] trial_out,
  output reg done_out,
  output wire [BITS-1:0] value_out
);
  reg [BITS-1:0] approx_reg;
  reg [BITS-1:0] probe_reg;
  reg [3:0] step_reg;
  reg busy_reg;
  wire [31:0] last_full;
  wire [3:0] last_step;
  assign last_full = res10_in ? (`CONV_CLKS_10BIT - 1) :
                                (`CONV_CLKS_8BIT - 1);
  assign last_step = last_full[3:0];
  assign trial_out = approx_reg | probe_reg;
  assign value_out = approx_reg;
  // the two extra clocks per conversion settle the dac before the first probe
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      approx_reg <= {BITS{1'b0}};
      probe_reg <= {BITS{1'b0}};
      step_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (abort_in) begin
        busy_reg <= 1'b0;
        probe_reg <= {BITS{1'b0}};
      end else if (start_in) begin
        busy_reg <= 1'b1;
        step_reg <= 4'h0;
        approx_reg <= {BITS{1'b0}};
        probe_reg <= {BITS{1'b0}};
      end else if (busy_reg && tick_in) begin
        step_reg <= step_reg + 4'h1;
        if (step_reg == 4'h1) begin
          // both resolutions search from the top bit; 8-bit stops two early
          probe_reg <= {1'b1, {(BITS-1){1'b0}}};
        end else if (step_reg > 4'h1 && probe_reg != {BITS{1'b0}}) begin
          if (comp_in) approx_reg <= approx_reg | probe_reg;
          probe_reg <= probe_reg >> 1;
        end
        if (step_reg == last_step) begin
          busy_reg <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== hdl/sar_converter_sequencer.v
// control sequencer of an eight channel successive approximation converter
// ===========================================================
// Function
// - select exactly one of eight inputs for each sample
// - sample capacitor two clocks, then amplifier charge four clocks
// - third direct phase lasts 2, 4, 8 or 16 clocks
// - 8 or 10 bit; conversion 10 or 12 clocks
// - binary search, then load result in selected format
// - 5-bit modulus prescaler divides by 1 to 32
// - module clock is prescaler output divided by two
// - power-up bit cleared stops digital clocks and analog bias
// - stop powers the block down like a cleared power-up bit
// - wait powers down only when stop-in-wait bit set
// - power-up bit resets to zero, so block starts powered down
// - any power-down request abandons the running sequence
// - registers kept on power-up; software waits for bias to settle
// - registers accessible while powered down by power-up bit
// - no register access while powered down through wait
// - sample and conversion clocks gated when not active
// - freeze select: ignore, finish then halt, or halt now
// - frozen state held, registers accessible, resumes on debug release
// - module reset by system reset or test register reset bit
// - test reset keeps power-up bit and returns to idle
// - each instance presents a 16-byte register block
// - sequence-complete and per-result conversion-complete flags set
// - sequences of one, four or eight conversions
`timescale 1ns/1ps
module sar_converter_sequencer #(
  parameter RES_BITS = 10,
  parameter PRESCALE_WIDTH = 5
) (
  input wire REF_CLK_IN,
  input wire RST_IN,
  input wire CE_IN,
  input wire [3:0] ADDR_IN,
  input wire [7:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output reg [7:0] RDATA_OUT,
  input wire STOP_IN,
  input wire WAIT_IN,
  input wire DEBUG_MODE_SIGNAL_IN,
  input wire COMP_IN,
  output reg [2:0] MUX_SEL_OUT,
  output reg MUX_EN_OUT,
  output reg SAMPLE_CAP_OUT,
  output reg AMP_CHARGE_OUT,
  output reg DIRECT_OUT,
  output wire [RES_BITS-1:0] DAC_TRIAL_OUT,
  output wire CONV_CLK_EN_OUT,
  output reg ANALOG_BIAS_EN_OUT,
  output wire BUSY_OUT
);
`include "sar_seq_defs.vh"
  // ===========================================================
  // states
  localparam S_IDLE = 3'h0;
  localparam S_CAP = 3'h1;
  localparam S_AMP = 3'h2;
  localparam S_DIRECT = 3'h3;
  localparam S_CONV = 3'h4;
  localparam S_STORE = 3'h5;

  reg [7:0] converter_control_two_reg;
  reg [7:0] converter_control_three_reg;
  reg [7:0] ctrl_four_reg;
  reg [7:0] ctrl_five_reg;
  reg [7:0] converter_test_register_reg;
  reg [2:0] rsel_reg;
  reg [15:0] result_mem [0:7];
  reg [7:0] conv_done_flags_reg;
  reg seq_done_flag_reg;
  reg [2:0] state_reg;
  reg [4:0] phase_cnt_reg;
  reg [2:0] conv_idx_reg;
  reg frozen_reg;
  reg finish_pend_reg;
  reg start_pulse_reg;
  reg rd_was_data_reg;

  wire powered;
  wire wait_down;
  wire mod_rst;
  wire tick;
  wire run_clk;
  wire acc_ok;
  wire sar_done;
  wire [RES_BITS-1:0] sar_value;
  wire [1:0] frz_sel;
  wire [4:0] direct_len;
  wire [3:0] seq_len;
  wire [2:0] chan_now;
  wire [15:0] fmt_value;
  wire abort;
  wire res10;
  wire freeze_now;
  wire freeze_next;
  wire seq_start_wr;

  assign res10 = ctrl_four_reg[`CT4_RES10];
  assign frz_sel = converter_control_three_reg[`CT3_FREEZE_HI:`CT3_FREEZE_LO];
  assign wait_down = WAIT_IN & converter_control_two_reg[`CT2_STOP_IN_WAIT];
  assign powered = converter_control_two_reg[`CT2_PWR_UP] & ~STOP_IN &
                   ~wait_down;
  assign abort = ~powered;
  assign mod_rst = converter_test_register_reg[`TEST_RESET_BIT];
  assign acc_ok = CE_IN & ~wait_down;
  assign freeze_now = DEBUG_MODE_SIGNAL_IN & (frz_sel == `FRZ_NOW);
  assign freeze_next = DEBUG_MODE_SIGNAL_IN & (frz_sel == `FRZ_FINISH);
  // prescaler runs only when powered and not frozen
  // a sequence start restarts the divider so the first phase is whole
  assign seq_start_wr = WR_IN & acc_ok & (ADDR_IN == `OFF_CTRL_FIVE) &
                        ~mod_rst;
  assign run_clk = powered & ~frozen_reg & ~freeze_now & ~seq_start_wr;
  assign CONV_CLK_EN_OUT = tick & (state_reg == S_CONV);
  assign BUSY_OUT = (state_reg != S_IDLE);
  // third phase 2 << smp: 2, 4, 8, 16
  assign direct_len = 5'h02 << ctrl_four_reg[`CT4_SAMPLE_HI:`CT4_SAMPLE_LO];
  assign seq_len = ctrl_five_reg[`CT5_LEN_EIGHT] ? 4'h8 :
                   converter_control_three_reg[`CT3_LEN_ONE] ? 4'h1 : 4'h4;
  assign chan_now = ctrl_five_reg[`CT5_MULT] ?
                    ctrl_five_reg[`CT5_CHAN_HI:`CT5_CHAN_LO] + conv_idx_reg :
                    ctrl_five_reg[`CT5_CHAN_HI:`CT5_CHAN_LO];
  assign fmt_value = ctrl_two_fmt(converter_control_two_reg[`CT2_JUSTIFY_RIGHT],
                                  res10, sar_value);

  function [15:0] ctrl_two_fmt;
    input right;
    input r10;
    input [RES_BITS-1:0] v;
    begin
      if (r10)
        ctrl_two_fmt = right ? {6'h00, v} : {v, 6'h00};
      else
        ctrl_two_fmt = right ? {8'h00, v[RES_BITS-1:2]} :
                               {v[RES_BITS-1:2], 8'h00};
    end
  endfunction

  sar_prescaler #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_prescaler (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .run_in(run_clk),
    .ratio_in(ctrl_four_reg[`CT4_PRESCALE_HI:`CT4_PRESCALE_LO]),
    .tick_out(tick)
  );

  sar_search #(
    .BITS(RES_BITS)
  ) u_search (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .tick_in(tick),
    .start_in(start_pulse_reg),
    .abort_in(abort | mod_rst | seq_start_wr),
    .res10_in(res10),
    .comp_in(COMP_IN),
    .trial_out(DAC_TRIAL_OUT),
    .done_out(sar_done),
    .value_out(sar_value)
  );

  // ===========================================================
  // register file and sequencer
  // registers stay writable while powered down by the power-up bit or stop, not through wait
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      converter_control_two_reg <= `CT2_RESET;
      converter_control_three_reg <= `CT3_RESET;
      ctrl_four_reg <= `CT4_RESET;
      ctrl_five_reg <= `CT5_RESET;
      converter_test_register_reg <= 8'h00;
      rsel_reg <= 3'h0;
      conv_done_flags_reg <= 8'h00;
      seq_done_flag_reg <= 1'b0;
      state_reg <= S_IDLE;
      phase_cnt_reg <= 5'h00;
      conv_idx_reg <= 3'h0;
      frozen_reg <= 1'b0;
      finish_pend_reg <= 1'b0;
      start_pulse_reg <= 1'b0;
      RDATA_OUT <= 8'h00;
      rd_was_data_reg <= 1'b0;
      MUX_SEL_OUT <= 3'h0;
      MUX_EN_OUT <= 1'b0;
      SAMPLE_CAP_OUT <= 1'b0;
      AMP_CHARGE_OUT <= 1'b0;
      DIRECT_OUT <= 1'b0;
      ANALOG_BIAS_EN_OUT <= 1'b0;
    end else if (CE_IN) begin
      start_pulse_reg <= 1'b0;
      ANALOG_BIAS_EN_OUT <= powered;
      RDATA_OUT <= 8'h00;
      // test reset: all but the power-up bit, the test register, result select and results
      if (mod_rst) begin
        // the reset bit itself stays writable so software can end it
        if (WR_IN && acc_ok && ADDR_IN == `OFF_TEST)
          converter_test_register_reg <= WDATA_IN;
        converter_control_two_reg <= converter_control_two_reg &
                                     (8'h01 << `CT2_PWR_UP);
        converter_control_three_reg <= `CT3_RESET;
        ctrl_four_reg <= `CT4_RESET;
        ctrl_five_reg <= `CT5_RESET;
        conv_done_flags_reg <= 8'h00;
        seq_done_flag_reg <= 1'b0;
        state_reg <= S_IDLE;
        conv_idx_reg <= 3'h0;
        frozen_reg <= 1'b0;
        finish_pend_reg <= 1'b0;
      end else begin
        // freeze tracking
        if (!DEBUG_MODE_SIGNAL_IN || frz_sel == `FRZ_IGNORE) begin
          frozen_reg <= 1'b0;
          finish_pend_reg <= 1'b0;
        end else if (freeze_now) begin
          frozen_reg <= 1'b1;
        end else if (freeze_next) begin
          finish_pend_reg <= 1'b1;
        end
        if (abort) begin
          state_reg <= S_IDLE;
        end else if (tick) begin
          case (state_reg)
            S_IDLE: begin
              phase_cnt_reg <= 5'h00;
            end
            S_CAP: begin
              if (phase_cnt_reg == `SAMPLE_CAP_CLKS - 1) begin
                phase_cnt_reg <= 5'h00;
                state_reg <= S_AMP;
              end else begin
                phase_cnt_reg <= phase_cnt_reg + 5'h01;
              end
            end
            S_AMP: begin
              if (phase_cnt_reg == `SAMPLE_AMP_CLKS - 1) begin
                phase_cnt_reg <= 5'h00;
                state_reg <= S_DIRECT;
              end else begin
                phase_cnt_reg <= phase_cnt_reg + 5'h01;
              end
            end
            S_DIRECT: begin
              if (phase_cnt_reg == direct_len - 5'h01) begin
                phase_cnt_reg <= 5'h00;
                state_reg <= S_CONV;
                start_pulse_reg <= 1'b1;
              end else begin
                phase_cnt_reg <= phase_cnt_reg + 5'h01;
              end
            end
            S_CONV: begin
            end
            default: state_reg <= S_IDLE;
          endcase
        end
        if (!abort && state_reg == S_CONV && sar_done)
          state_reg <= S_STORE;
        if (!abort && state_reg == S_STORE) begin
          result_mem[conv_idx_reg] <= fmt_value;
          conv_done_flags_reg[conv_idx_reg] <= 1'b1;
          if ({1'b0, conv_idx_reg} == seq_len - 4'h1) begin
            seq_done_flag_reg <= 1'b1;
            conv_idx_reg <= 3'h0;
            state_reg <= ctrl_five_reg[`CT5_SCAN] ? S_CAP : S_IDLE;
          end else begin
            conv_idx_reg <= conv_idx_reg + 3'h1;
            state_reg <= S_CAP;
          end
          // finish-then-halt freezes before the next sample
          if (finish_pend_reg || freeze_next)
            frozen_reg <= 1'b1;
        end
        // writes into the 16-byte block
        if (WR_IN && acc_ok) begin
          case (ADDR_IN)
            `OFF_CTRL_TWO: converter_control_two_reg <= WDATA_IN;
            `OFF_CTRL_THREE: converter_control_three_reg <= WDATA_IN;
            `OFF_CTRL_FOUR: ctrl_four_reg <= WDATA_IN;
            `OFF_CTRL_FIVE: begin
              ctrl_five_reg <= WDATA_IN;
              conv_idx_reg <= 3'h0;
              state_reg <= powered ? S_CAP : S_IDLE;
              phase_cnt_reg <= 5'h00;
              // a store in this very cycle keeps its flags: set wins
              if (abort || state_reg != S_STORE) begin
                seq_done_flag_reg <= 1'b0;
                conv_done_flags_reg <= 8'h00;
              end
            end
            `OFF_TEST: converter_test_register_reg <= WDATA_IN;
            `OFF_RESULT_SEL: rsel_reg <= WDATA_IN[2:0];
            default: ;
          endcase
        end
        // reads; none served while in wait power down
        if (RD_IN && acc_ok) begin
          case (ADDR_IN)
            `OFF_CTRL_TWO: RDATA_OUT <= converter_control_two_reg;
            `OFF_CTRL_THREE: RDATA_OUT <= converter_control_three_reg;
            `OFF_CTRL_FOUR: RDATA_OUT <= ctrl_four_reg;
            `OFF_CTRL_FIVE: RDATA_OUT <= ctrl_five_reg;
            `OFF_STATUS: RDATA_OUT <= {seq_done_flag_reg, 1'b0,
                                       BUSY_OUT, frozen_reg, 1'b0,
                                       conv_idx_reg};
            `OFF_TEST: RDATA_OUT <= converter_test_register_reg;
            `OFF_RESULT_SEL: RDATA_OUT <= conv_done_flags_reg;
            `OFF_RESULT_DATA: RDATA_OUT <= result_mem[rsel_reg][15:8];
            `OFF_RESULT_DATA + 4'h1: RDATA_OUT <= result_mem[rsel_reg][7:0];
            default: RDATA_OUT <= 8'h00;
          endcase
        end
      end
      // analog front end strobes, registered
      MUX_SEL_OUT <= chan_now;
      MUX_EN_OUT <= (state_reg == S_CAP) || (state_reg == S_DIRECT);
      SAMPLE_CAP_OUT <= (state_reg == S_CAP);
      AMP_CHARGE_OUT <= (state_reg == S_AMP);
      DIRECT_OUT <= (state_reg == S_DIRECT);
    end
  end
endmodule

// ===== verification/sar_seq_monitor.sv
// port assertions for the converter sequencer
`timescale 1ns/1ps
module sar_seq_monitor (
  input wire REF_CLK_IN,
  input wire RST_IN,
  input wire CE_IN,
  input wire RD_IN,
  input wire STOP_IN,
  input wire [7:0] RDATA_OUT,
  input wire [2:0] MUX_SEL_OUT,
  input wire MUX_EN_OUT,
  input wire SAMPLE_CAP_OUT,
  input wire AMP_CHARGE_OUT,
  input wire DIRECT_OUT,
  input wire CONV_CLK_EN_OUT,
  input wire ANALOG_BIAS_EN_OUT,
  input wire BUSY_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  // ==========
  // sample phases
  one_phase_a: assert property (
    $onehot0({SAMPLE_CAP_OUT, AMP_CHARGE_OUT, DIRECT_OUT}))
    else $error("two sample phases at once");
  mux_enable_a: assert property (
    MUX_EN_OUT == (SAMPLE_CAP_OUT | DIRECT_OUT))
    else $error("mux enable outside cap or direct phase");
  mux_hold_a: assert property (
    MUX_EN_OUT && $past(MUX_EN_OUT) |-> $stable(MUX_SEL_OUT))
    else $error("channel moved within a phase");
  amp_follow_a: assert property (
    $fell(SAMPLE_CAP_OUT) && ANALOG_BIAS_EN_OUT |-> AMP_CHARGE_OUT)
    else $error("amplifier phase did not follow cap phase");
  direct_follow_a: assert property (
    $fell(AMP_CHARGE_OUT) && ANALOG_BIAS_EN_OUT |-> DIRECT_OUT)
    else $error("direct phase did not follow amplifier phase");
  // ==========
  // clocking and power
  conv_quiet_a: assert property (
    CONV_CLK_EN_OUT |-> BUSY_OUT &&
      !(SAMPLE_CAP_OUT | AMP_CHARGE_OUT | DIRECT_OUT))
    else $error("conversion clock outside conversion");
  tick_gap_a: assert property (
    CONV_CLK_EN_OUT |=> !CONV_CLK_EN_OUT)
    else $error("module ticks closer than two clocks");
  down_quiet_a: assert property (
    !ANALOG_BIAS_EN_OUT && $past(!ANALOG_BIAS_EN_OUT) |->
      !BUSY_OUT && !CONV_CLK_EN_OUT)
    else $error("activity while powered down");
  stop_down_a: assert property (
    (STOP_IN && CE_IN) [*3] |-> !ANALOG_BIAS_EN_OUT)
    else $error("bias still on in stop");
  read_quiet_a: assert property (
    !$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data outside read answer cycle");
  ce_freeze_a: assert property (
    !$past(CE_IN) |-> $stable({MUX_SEL_OUT, MUX_EN_OUT, SAMPLE_CAP_OUT,
      AMP_CHARGE_OUT, DIRECT_OUT, ANALOG_BIAS_EN_OUT}))
    else $error("state moved with clock enable low");
  cover property (CONV_CLK_EN_OUT);
  cover property ($fell(DIRECT_OUT));
  cover property (STOP_IN && BUSY_OUT);
  cover property (!CE_IN && BUSY_OUT);
endmodule

bind sar_converter_sequencer sar_seq_monitor u_mon (
  .REF_CLK_IN(REF_CLK_IN),
  .RST_IN(RST_IN),
  .CE_IN(CE_IN),
  .RD_IN(RD_IN),
  .STOP_IN(STOP_IN),
  .RDATA_OUT(RDATA_OUT),
  .MUX_SEL_OUT(MUX_SEL_OUT),
  .MUX_EN_OUT(MUX_EN_OUT),
  .SAMPLE_CAP_OUT(SAMPLE_CAP_OUT),
  .AMP_CHARGE_OUT(AMP_CHARGE_OUT),
  .DIRECT_OUT(DIRECT_OUT),
  .CONV_CLK_EN_OUT(CONV_CLK_EN_OUT),
  .ANALOG_BIAS_EN_OUT(ANALOG_BIAS_EN_OUT),
  .BUSY_OUT(BUSY_OUT)
);

// ===== verification/sar_analog_model.sv
// multiplexer, hold node and comparator model of the analog side
`timescale 1ns/1ps
module sar_analog_model (
  input wire clk_in,
  input wire [9:0] base_in,
  input wire [2:0] mux_sel_in,
  input wire mux_en_in,
  input wire [9:0] trial_in,
  output wire comp_out
);
  reg [9:0] held_reg;
  initial held_reg = 10'h000;
  // each channel has its own level so a wrong select shows in the result
  always @(posedge clk_in) begin
    if (mux_en_in) begin
      held_reg <= base_in + {7'h00, mux_sel_in} * 10'h025;
    end
  end
  // level equals its code; a tie compares as above, so the search lands on the code
  assign comp_out = (held_reg >= trial_in);
endmodule

// ===== verification/sar_converter_sequencer_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "sar_seq_defs.vh"
module sar_converter_sequencer_tb;
  reg clk, rst, ce, wr, rd, stp, wt, dbg, clr, dir_d;
  reg [3:0] addr;
  reg [7:0] wd, got, hi;
  reg [9:0] base, tr;
  reg [2:0] ch;
  wire [7:0] rdo;
  wire [2:0] msel;
  wire [9:0] trial;
  wire men, cap, amp, dir, cen, bias, busy, comp;
  integer num_errors, checked, n_amp, n_dir, n_tk, n_smp, n_bad, i;
  sar_converter_sequencer u_dut (.REF_CLK_IN(clk), .RST_IN(rst),
    .CE_IN(ce), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdo), .STOP_IN(stp), .WAIT_IN(wt),
    .DEBUG_MODE_SIGNAL_IN(dbg), .COMP_IN(comp), .MUX_SEL_OUT(msel),
    .MUX_EN_OUT(men), .SAMPLE_CAP_OUT(cap), .AMP_CHARGE_OUT(amp),
    .DIRECT_OUT(dir), .DAC_TRIAL_OUT(trial), .CONV_CLK_EN_OUT(cen),
    .ANALOG_BIAS_EN_OUT(bias), .BUSY_OUT(busy));
  sar_analog_model u_ana (.clk_in(clk), .base_in(base),
    .mux_sel_in(msel), .mux_en_in(men), .trial_in(trial),
    .comp_out(comp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========
  // activity counters
  always @(posedge clk) begin
    dir_d <= dir;
    n_amp <= clr ? 0 : n_amp + amp;
    n_dir <= clr ? 0 : n_dir + dir;
    n_tk <= clr ? 0 : n_tk + cen;
    n_smp <= clr ? 0 : n_smp + (dir_d & !dir);
    n_bad <= clr ? 0 : n_bad + (men && msel !== ch);
  end
  // ==========
  // bus and check helpers
  task tally(input ok);
    begin
      checked = checked + 1;
      if (ok !== 1'b1) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t mismatch", $time);
      end
    end
  endtask
  task wr8(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd8(input [3:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdo;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task clr_cnt;
    begin
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
    end
  endtask
  task wait_tick;
    begin
      for (i = 0; i < 9000 && cen !== 1'b1; i = i + 1) cyc(1);
    end
  endtask
  task wait_idle;
    begin
      cyc(1);
      for (i = 0; i < 30000 && busy !== 1'b0; i = i + 1) cyc(1);
      tally(busy === 1'b0);
    end
  endtask
  // ==========
  // scenarios
  task t_reset;
    begin
      tally(bias === 1'b0);
      rd8(`OFF_CTRL_TWO);
      tally(got === `CT2_RESET);
      rd8(`OFF_CTRL_FOUR);
      tally(got === `CT4_RESET);
      rd8(4'hf);
      tally(got === 8'h00);
      wr8(`OFF_CTRL_THREE, 8'h06);
      rd8(`OFF_CTRL_THREE);
      tally(got === 8'h06);
      $display("reset test done");
    end
  endtask
  task t_conv(input r10, input rj, input [1:0] s, input [4:0] n,
      input [1:0] lc, input [2:0] c);
    reg [9:0] lv;
    reg [15:0] ex;
    integer nc;
    begin
      nc = (lc == 2'h2) ? 8 : (lc == 2'h0) ? 1 : 4;
      lv = base + {7'h00, c} * 10'h025;
      ch = c;
      wr8(`OFF_CTRL_TWO, {2'b10, rj, 5'h00});
      cyc(8);
      wr8(`OFF_CTRL_THREE, {5'h00, lc == 2'h0, 2'h0});
      wr8(`OFF_CTRL_FOUR, {r10, s, n});
      clr_cnt;
      wr8(`OFF_CTRL_FIVE, {1'b0, lc == 2'h2, 3'h0, c});
      wait_idle;
      tally(n_smp === nc);
      tally(n_amp === nc * 8 * (n + 1));
      tally(n_dir === nc * (4 << s) * (n + 1));
      tally(n_tk === nc * (r10 ? 12 : 10));
      tally(n_bad === 0);
      rd8(`OFF_STATUS);
      tally(got[7] === 1'b1);
      rd8(`OFF_RESULT_SEL);
      tally(got[0] === 1'b1);
      wr8(`OFF_RESULT_SEL, 8'h00);
      rd8(`OFF_RESULT_DATA);
      hi = got;
      rd8(`OFF_RESULT_DATA + 4'h1);
      if (r10)
        ex = rj ? {6'h00, lv} : {lv, 6'h00};
      else
        ex = rj ? {8'h00, lv[9:2]} : {lv[9:2], 8'h00};
      tally({hi, got} === ex);
      $display("conversion test done");
    end
  endtask
  task t_power;
    begin
      wr8(`OFF_CTRL_THREE, 8'h00);
      wr8(`OFF_CTRL_FOUR, 8'h80);
      wr8(`OFF_CTRL_FIVE, 8'h00);
      wait_tick;
      wr8(`OFF_CTRL_TWO, 8'h00);
      cyc(2);
      tally(busy === 1'b0 && bias === 1'b0);
      wr8(`OFF_CTRL_FOUR, 8'h85);
      wr8(`OFF_CTRL_TWO, 8'h80);
      rd8(`OFF_CTRL_FOUR);
      tally(got === 8'h85 && bias === 1'b1);
      wr8(`OFF_CTRL_FIVE, 8'h00);
      wait_tick;
      @(posedge clk);
      stp <= 1'b1;
      cyc(4);
      tally(busy === 1'b0 && bias === 1'b0);
      @(posedge clk);
      stp <= 1'b0;
      rd8(`OFF_CTRL_TWO);
      tally(got === 8'h80);
      wr8(`OFF_CTRL_FIVE, 8'h00);
      @(posedge clk);
      wt <= 1'b1;
      cyc(4);
      tally(busy === 1'b1);
      wait_idle;
      @(posedge clk);
      wt <= 1'b0;
      wr8(`OFF_CTRL_TWO, 8'hc0);
      wr8(`OFF_CTRL_FIVE, 8'h00);
      wait_tick;
      @(posedge clk);
      wt <= 1'b1;
      cyc(4);
      tally(busy === 1'b0 && bias === 1'b0);
      rd8(`OFF_CTRL_TWO);
      tally(got === 8'h00);
      wr8(`OFF_CTRL_FOUR, 8'h01);
      @(posedge clk);
      wt <= 1'b0;
      rd8(`OFF_CTRL_FOUR);
      tally(got === 8'h85);
      $display("power test done");
    end
  endtask
  task t_freeze(input [1:0] m);
    begin
      wr8(`OFF_CTRL_TWO, 8'h80);
      wr8(`OFF_CTRL_THREE, {6'h00, m});
      wr8(`OFF_CTRL_FOUR, 8'h80);
      wr8(`OFF_CTRL_FIVE, 8'h00);
      wait_tick;
      @(posedge clk);
      dbg <= 1'b1;
      cyc(3);
      tr = trial;
      clr_cnt;
      cyc(200);
      if (m == `FRZ_IGNORE)
        tally(busy === 1'b0);
      else
        tally(busy === 1'b1 && n_amp === 0);
      if (m == `FRZ_NOW)
        tally(n_tk === 0 && trial === tr);
      rd8(`OFF_CTRL_FOUR);
      tally(got === 8'h80);
      @(posedge clk);
      dbg <= 1'b0;
      wait_idle;
      rd8(`OFF_STATUS);
      tally(got[7] === 1'b1);
      $display("freeze test done");
    end
  endtask
  task t_treset;
    begin
      wr8(`OFF_CTRL_FOUR, 8'h83);
      wr8(`OFF_CTRL_FIVE, 8'h00);
      wait_tick;
      clr_cnt;
      ce <= 1'b0;
      cyc(20);
      tally(n_tk === 0);
      @(posedge clk);
      ce <= 1'b1;
      wr8(`OFF_TEST, 8'h01);
      wr8(`OFF_TEST, 8'h00);
      cyc(1);
      tally(busy === 1'b0 && bias === 1'b1);
      rd8(`OFF_CTRL_TWO);
      tally(got === 8'h80);
      rd8(`OFF_CTRL_FOUR);
      tally(got === `CT4_RESET);
      $display("test reset test done");
    end
  endtask
  task t_multi;
    begin
      wr8(`OFF_CTRL_TWO, 8'ha0);
      wr8(`OFF_CTRL_THREE, 8'h00);
      wr8(`OFF_CTRL_FOUR, 8'h80);
      wr8(`OFF_CTRL_FIVE, 8'h12);
      wait_idle;
      wr8(`OFF_RESULT_SEL, 8'h01);
      rd8(`OFF_RESULT_DATA);
      hi = got;
      rd8(`OFF_RESULT_DATA + 4'h1);
      tally({hi, got} === {6'h00, base + 10'h06f});
      wr8(`OFF_CTRL_FIVE, 8'h22);
      cyc(400);
      rd8(`OFF_STATUS);
      tally(got[7] === 1'b1 && busy === 1'b1);
      wr8(`OFF_CTRL_TWO, 8'h00);
      cyc(2);
      tally(busy === 1'b0);
      $display("multi and scan test done");
    end
  endtask
  task give_verdict;
    begin
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ==========
  // main sequence and watchdog
  initial begin
    rst = 1'b1;
    {ce, wr, rd, stp, wt, dbg, clr} = 7'h40;
    addr = 4'h0;
    wd = 8'h00;
    base = 10'h155;
    ch = 3'h0;
    {n_amp, n_dir, n_tk, n_smp, n_bad} = 0;
    num_errors = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_conv(1'b1, 1'b0, 2'h0, 5'h00, 2'h0, 3'h3);
    t_conv(1'b1, 1'b1, 2'h3, 5'h1f, 2'h0, 3'h7);
    t_conv(1'b0, 1'b0, 2'h1, 5'h01, 2'h1, 3'h0);
    t_conv(1'b0, 1'b1, 2'h2, 5'h02, 2'h2, 3'h5);
    t_power;
    t_freeze(`FRZ_IGNORE);
    t_freeze(`FRZ_FINISH);
    t_freeze(`FRZ_NOW);
    t_treset;
    t_multi;
    give_verdict;
  end
  initial begin
    #900000;
    num_errors = num_errors + 1;
    give_verdict;
  end
endmodule
